// ==== spc_defs.svh ====
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// ---------------------------------------------------------------
// opcodes, sent msb first
// ---------------------------------------------------------------
`define SPC_OP_MEM_READ   8'h03
`define SPC_OP_MEM_WRITE  8'h02
`define SPC_OP_CFG_WRITE  8'h09
`define SPC_OP_CTRL_WRITE 8'h0A
`define SPC_OP_STAT_READ  8'h0B
`define SPC_OP_LOCK       8'h01
`define SPC_OP_LOCK_READ  8'h05
`define SPC_OP_LATCH_SET  8'h06
`define SPC_OP_LATCH_CLR  8'h04

// ---------------------------------------------------------------
// array geometry and reset values
// ---------------------------------------------------------------
`define SPC_MEM_DEPTH     512
`define SPC_ADDR_W        9
`define SPC_ADDR_ONE      9'h001
`define SPC_PAGE_ONE      4'h1
`define SPC_ERASED        8'hFF
`define SPC_CFG_RESET     16'h0000
`define SPC_CTRL_RESET    16'h0000
`define SPC_LOCK_RESET    3'h0
`define SPC_PIN_RESET     3'h4

// lock windows, nine bits per select code, code 7 leftmost
// code 0 has lo above hi and so locks nothing
`define SPC_LK_LO {9'h1F0, 9'h000, 9'h000, 9'h180, \
                   9'h100, 9'h080, 9'h000, 9'h1FF}
`define SPC_LK_HI {9'h1FF, 9'h00F, 9'h0FF, 9'h1FF, \
                   9'h17F, 9'h0FF, 9'h07F, 9'h000}

`endif

// ==== spc_pkg.sv ====
`default_nettype none

package spc_pkg;

  // ---------------------------------------------------------------
  // command sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [9:0] {
    SPC_OPC   = 10'h001,
    SPC_ADDR  = 10'h002,
    SPC_RD    = 10'h004,
    SPC_WR    = 10'h008,
    SPC_REG   = 10'h010,
    SPC_STAT  = 10'h020,
    SPC_LOCKB = 10'h040,
    SPC_LKEND = 10'h080,
    SPC_WEN   = 10'h100,
    SPC_VOID  = 10'h200
  } spc_state_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } spc_pins_t;

  typedef struct packed {
    logic [6:0] spare;
    logic       sleep;
    logic [1:0] gain;
    logic [3:0] balance;
    logic       dfet;
    logic       cfet;
  } spc_ctrl_t;

  typedef struct packed {
    logic       we;
    logic [8:0] addr;
    logic [7:0] data;
  } spc_wreq_t;

  // ---------------------------------------------------------------
  // command port state
  // ---------------------------------------------------------------
  typedef struct packed {
    spc_state_t st;
    logic       sck_d;
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [6:0] rx;
    logic [7:0] tx;
    logic       so;
    logic       drive;
    logic [8:0] addr;
    logic       is_read;
    logic       is_ctrl;
    logic [7:0] hi;
    logic [2:0] lock_pend;
    logic [2:0] lock_sel;
    logic       latch;
    logic [15:0] cfg;
    spc_ctrl_t  ctrl;
  } spc_core_t;

endpackage : spc_pkg

`default_nettype wire

// ==== spc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module spc_sync #(
  parameter int         W       = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spc_sync_t;

  spc_sync_t q_r;
  spc_sync_t q_nxt;

  // first stage feeds only the second stage
  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = din;
    q_nxt.s2 = q_r.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q_r <= {RST_VAL, RST_VAL};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign dout = q_r.s2;

endmodule : spc_sync

`default_nettype wire

// ==== spc_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

// depth default needs the macros before the header is read
`include "spc_defs.svh"

module spc_mem
  import spc_pkg::*;
#(
  parameter int DEPTH = `SPC_MEM_DEPTH
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // write request and lock selection
  input  wire spc_wreq_t  wreq,
  input  wire logic [2:0] lock_sel,
  // read port
  input  wire logic [8:0] rd_addr,
  output logic      [7:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] cells;
  } spc_mem_t;

  localparam logic [71:0] LK_LO = `SPC_LK_LO;
  localparam logic [71:0] LK_HI = `SPC_LK_HI;

  spc_mem_t q_r;
  spc_mem_t q_nxt;
  logic     hit_lock;

  // window test; a locked cell is never overwritten [R12]
  always_comb begin
    hit_lock = (wreq.addr >= LK_LO[lock_sel*9 +: 9]) &&
               (wreq.addr <= LK_HI[lock_sel*9 +: 9]);
  end

  // write only outside the locked window [R12]
  always_comb begin
    q_nxt = q_r;
    if (wreq.we && !hit_lock) begin
      q_nxt.cells[wreq.addr] = wreq.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q_r <= {DEPTH{`SPC_ERASED}};
    end else begin
      q_r <= q_nxt;
    end
  end

  // asynchronous read keeps byte-boundary loads in one cycle
  assign rd_data = q_r.cells[rd_addr];

endmodule : spc_mem

`default_nettype wire

// ==== spc_port.sv ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// serial command port
// ---------------------------------------------------------------

// Behaviour
// R01: a read frame is opcode then a 16-bit address using its low 9 bits.
// R02: after opcode and address the addressed byte goes out on serial out.
// R03: the read address steps by one per byte so reads stream on.
// R04: the read address wraps from 01FFh to 0000h without limit.
// R05: chip select high ends a read and releases serial out.
// R06: the configuration write takes effect as soon as it completes.
// R07: the host copies new configuration into the array to keep it.
// R08: the control write drives fets, balance, gain and sleep request.
// R09: after a control write the next command is taken with no wait.
// R10: status read returns the three status flags on serial out.
// R11: the lock command picks one of eight lock configurations.
// R12: a locked region keeps its contents under a valid write.
// R13: mode 0, sample on clock rise, shift out on clock fall, msb first.
// R14: opcodes are read 03h, config 09h, control 0Ah, status 0Bh, lock 01h.
// R15: config and control writes carry exactly two data bytes.
// R16: the host sets the write latch before any nonvolatile write.
// R17: chip select high mid-command drops it and clears the bit counter.
module spc_port
  import spc_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // serial pins, outside the clock domain
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe_n,
  // status flags, same clock domain
  input  wire logic [2:0]  status_flags,
  // configuration word
  output logic      [15:0] cfg_word,
  // control outputs
  output logic             cfet_on,
  output logic             dfet_on,
  output logic      [3:0]  balance_on,
  output logic      [1:0]  sense_gain,
  output logic             sleep_req,
  // lock and write latch state
  output logic      [2:0]  lock_partition_select,
  output logic             write_latch
);

`include "spc_defs.svh"

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  spc_pins_t pins_raw;
  spc_pins_t pins_s;

  assign pins_raw = '{cs_n: cs_n, sck: sck, si: si};

  // chip select resets high so no false frame at start-up
  spc_sync #(
    .W       (3),
    .RST_VAL (`SPC_PIN_RESET)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (pins_raw),
    .dout    (pins_s)
  );

  // ---------------------------------------------------------------
  // array
  // ---------------------------------------------------------------
  spc_core_t  q_r;
  spc_core_t  q_nxt;
  spc_wreq_t  wreq;
  logic [8:0] rd_addr;
  logic [7:0] rd_data;

  spc_mem u_mem (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .wreq     (wreq),
    .lock_sel (q_r.lock_sel),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  // ---------------------------------------------------------------
  // edge detection on the synchronised clock
  // ---------------------------------------------------------------
  logic       sck_rise;
  logic       sck_fall;
  logic       byte_done;
  logic [7:0] rx_byte;

  // edges come from the second stage against a third copy [R13]
  assign sck_rise  = pins_s.sck & ~q_r.sck_d;
  assign sck_fall  = ~pins_s.sck & q_r.sck_d;
  // msb first, so the newest bit lands in bit 0 [R13]
  assign rx_byte   = {q_r.rx, pins_s.si};
  assign byte_done = sck_rise && (q_r.bit_cnt == 3'h7);

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_comb begin
    q_nxt       = q_r;
    wreq        = '0;
    rd_addr     = q_r.addr;
    q_nxt.sck_d = pins_s.sck;

    if (pins_s.cs_n) begin
      // frame end: drop partial work, release the pin [R05] [R17]
      q_nxt.st       = SPC_OPC;
      q_nxt.bit_cnt  = 3'h0;
      q_nxt.byte_idx = 2'h0;
      q_nxt.drive    = 1'b0;
      q_nxt.so       = 1'b0;
      // latch set needs exactly the eight opcode bits
      if (q_r.st == SPC_WEN && q_r.bit_cnt == 3'h0) begin
        q_nxt.latch = 1'b1;
      end
      // lock commits only on a whole two-byte frame [R11]
      if (q_r.st == SPC_LKEND && q_r.bit_cnt == 3'h0) begin
        if (q_r.latch) begin // [R16]
          q_nxt.lock_sel = q_r.lock_pend;
        end
        q_nxt.latch = 1'b0;
      end
      // a finished array write consumes the latch
      if (q_r.st == SPC_WR) begin
        q_nxt.latch = 1'b0;
      end
    end else begin
      // output changes on the falling edge only [R13]
      if (sck_fall && q_r.drive) begin
        q_nxt.so = q_r.tx[7];
        q_nxt.tx = {q_r.tx[6:0], 1'b0};
      end

      // input is taken on the rising edge only [R13]
      if (sck_rise) begin
        q_nxt.rx      = rx_byte[6:0];
        q_nxt.bit_cnt = q_r.bit_cnt + 3'h1;
      end

      if (byte_done) begin
        if (q_r.byte_idx != 2'h3) begin
          q_nxt.byte_idx = q_r.byte_idx + 2'h1;
        end
        unique case (q_r.st)
          // decode; any opcode taken at once, no wait [R09] [R14]
          SPC_OPC: begin
            q_nxt.byte_idx = 2'h0;
            unique case (rx_byte)
              `SPC_OP_MEM_READ: begin // [R01]
                q_nxt.st      = SPC_ADDR;
                q_nxt.is_read = 1'b1;
              end
              `SPC_OP_MEM_WRITE: begin
                q_nxt.st      = SPC_ADDR;
                q_nxt.is_read = 1'b0;
              end
              `SPC_OP_CFG_WRITE: begin // [R15]
                q_nxt.st      = SPC_REG;
                q_nxt.is_ctrl = 1'b0;
              end
              `SPC_OP_CTRL_WRITE: begin // [R15]
                q_nxt.st      = SPC_REG;
                q_nxt.is_ctrl = 1'b1;
              end
              `SPC_OP_STAT_READ: begin
                // flags sit in the low three bits [R10]
                q_nxt.st    = SPC_STAT;
                q_nxt.tx    = {5'h00, status_flags};
                q_nxt.drive = 1'b1;
              end
              `SPC_OP_LOCK_READ: begin
                q_nxt.st    = SPC_STAT;
                q_nxt.tx    = {5'h00, q_r.lock_sel};
                q_nxt.drive = 1'b1;
              end
              `SPC_OP_LOCK: begin
                q_nxt.st = SPC_LOCKB;
              end
              `SPC_OP_LATCH_SET: begin
                q_nxt.st = SPC_WEN;
              end
              `SPC_OP_LATCH_CLR: begin
                q_nxt.latch = 1'b0;
                q_nxt.st    = SPC_VOID;
              end
              default: begin
                q_nxt.st = SPC_VOID;
              end
            endcase
          end

          // high byte gives bit 8 only, upper bits ignored [R01]
          SPC_ADDR: begin
            if (q_r.byte_idx == 2'h0) begin
              q_nxt.addr[8] = rx_byte[0];
            end else begin
              q_nxt.addr[7:0] = rx_byte;
              if (q_r.is_read) begin
                // first byte loads on the address's last bit [R02]
                rd_addr     = {q_r.addr[8], rx_byte};
                q_nxt.tx    = rd_data;
                q_nxt.drive = 1'b1;
                // nine-bit add wraps 1FFh to 000h [R03] [R04]
                q_nxt.addr  = {q_r.addr[8], rx_byte} + `SPC_ADDR_ONE;
                q_nxt.st    = SPC_RD;
              end else begin
                q_nxt.st = SPC_WR;
              end
            end
          end

          // next byte each eight clocks, no limit [R03] [R04]
          SPC_RD: begin
            rd_addr    = q_r.addr;
            q_nxt.tx   = rd_data;
            q_nxt.addr = q_r.addr + `SPC_ADDR_ONE;
          end

          // each byte written as it completes, rolling in its page
          SPC_WR: begin
            wreq.we   = q_r.latch; // [R16]
            wreq.addr = q_r.addr;
            wreq.data = rx_byte;
            q_nxt.addr[3:0] = q_r.addr[3:0] + `SPC_PAGE_ONE;
          end

          // two data bytes, applied on the second byte's last bit
          SPC_REG: begin
            if (q_r.byte_idx == 2'h0) begin
              q_nxt.hi = rx_byte;
            end else begin
              if (q_r.is_ctrl) begin
                q_nxt.ctrl = {q_r.hi, rx_byte}; // [R08] [R15]
              end else begin
                q_nxt.cfg = {q_r.hi, rx_byte}; // [R06] [R15]
              end
              // extra bytes are ignored, not a second write
              q_nxt.st = SPC_VOID;
            end
          end

          // status repeats while the host keeps clocking [R10]
          SPC_STAT: begin
            q_nxt.tx = q_r.tx;
          end

          // low three bits pick the configuration [R11]
          SPC_LOCKB: begin
            q_nxt.lock_pend = rx_byte[2:0];
            q_nxt.st        = SPC_LKEND;
          end

          // more bytes than the command takes spoil it
          SPC_LKEND, SPC_WEN: begin
            q_nxt.st = SPC_VOID;
          end

          SPC_VOID: begin
            q_nxt.st = SPC_VOID;
          end
        endcase
      end

      // status reload keeps the byte stable across a boundary
      if (byte_done && q_r.st == SPC_STAT) begin
        q_nxt.tx = {5'h00, status_flags};
      end

      // partial lock or latch frames void on a stray bit
      if (sck_rise && !byte_done &&
          (q_r.st == SPC_LKEND || q_r.st == SPC_WEN)) begin
        q_nxt.st = SPC_VOID;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q_r           <= '0;
      q_r.st        <= SPC_OPC;
      q_r.cfg       <= `SPC_CFG_RESET;
      q_r.ctrl      <= `SPC_CTRL_RESET;
      q_r.lock_sel  <= `SPC_LOCK_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------
  // enable low only while a read or status byte is out [R05]
  assign so                    = q_r.so;
  assign so_oe_n               = ~q_r.drive;
  assign cfg_word              = q_r.cfg;
  // control word drives the pins directly [R08]
  assign cfet_on               = q_r.ctrl.cfet;
  assign dfet_on               = q_r.ctrl.dfet;
  assign balance_on            = q_r.ctrl.balance;
  assign sense_gain            = q_r.ctrl.gain;
  assign sleep_req             = q_r.ctrl.sleep;
  assign lock_partition_select = q_r.lock_sel;
  assign write_latch           = q_r.latch;

endmodule : spc_port

`default_nettype wire

// ==== spc_port_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// serial command port checker
// ---------------------------------------------------------------
module spc_port_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // serial pins
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        so,
  input wire logic        so_oe_n,
  // register outputs
  input wire logic [15:0] cfg_word,
  input wire logic        cfet_on,
  input wire logic        dfet_on,
  input wire logic [3:0]  balance_on,
  input wire logic [1:0]  sense_gain,
  input wire logic        sleep_req,
  input wire logic [2:0]  lock_partition_select,
  input wire logic        write_latch
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // control outputs gathered so one check covers them all
  logic [8:0] ctrl_v;
  assign ctrl_v = {sleep_req, sense_gain, balance_on, dfet_on, cfet_on};

  // deselect long enough to have crossed the synchronisers
  sequence s_cs_idle;
    cs_n [*6];
  endsequence

  a_oe_idle_high: assert property (s_cs_idle |-> so_oe_n)
    else $error("output enable still active after deselect");
  a_so_idle_low: assert property (s_cs_idle |-> !so)
    else $error("serial out not parked low after deselect");
  a_oe_in_frame: assert property (!so_oe_n |-> $past(!cs_n, 5))
    else $error("serial out driven outside a frame");
  a_so_after_fall: assert property (
    !so_oe_n && $past(!so_oe_n) && $changed(so) |-> $past(!sck, 2))
    else $error("serial out changed while clock high");
  a_cfg_in_frame: assert property (
    $changed(cfg_word) |-> !cs_n && $past(!cs_n, 4))
    else $error("configuration changed outside a frame");
  a_ctrl_in_frame: assert property (
    $changed(ctrl_v) |-> !cs_n && $past(!cs_n, 4))
    else $error("control outputs changed outside a frame");
  a_lock_at_end: assert property (
    $changed(lock_partition_select) |-> $past(cs_n, 2) && $past(!cs_n, 7))
    else $error("lock changed away from end of frame");
  a_lock_needs_latch: assert property (
    $changed(lock_partition_select) |-> $past(write_latch))
    else $error("lock changed without write latch");
endmodule : spc_port_chk

`default_nettype wire

// ==== spc_host.sv ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// host model, mode 0 master at a 160 ns bit period
// ---------------------------------------------------------------
module spc_host (
  // clock
  input  wire logic sys_clk,
  // serial pins, host side
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  int gap = 0; // idle cycles after each byte, a slow host stalls here

  // deselected with the clock parked low
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // select, then let the select cross the synchronisers
  task open;
    @(posedge sys_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : open

  // msb first, si set while low, so taken at the rise
  task xfer(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      si <= d[i];
      repeat (8) @(posedge sys_clk);
      sck  <= 1'b1;
      r[i] = so;
      repeat (8) @(posedge sys_clk);
      sck <= 1'b0;
    end
    repeat (gap) @(posedge sys_clk);
  endtask : xfer

  // deselect ends the command; si no longer carries meaning
  task close;
    @(posedge sys_clk);
    cs_n <= 1'b1;
    si   <= ~si;
    repeat (6) @(posedge sys_clk);
  endtask : close
endmodule : spc_host

`default_nettype wire

// ==== spc_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// serial command port bench
// ---------------------------------------------------------------
module spc_port_tb;
  import spc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  wire logic   cs_n;
  wire logic   sck;
  wire logic   si;
  logic        so;
  logic        so_oe_n;
  logic        so_pin;
  logic [2:0]  status_flags = 3'h5;
  logic [15:0] cfg_word;
  logic        cfet_on;
  logic        dfet_on;
  logic [3:0]  balance_on;
  logic [1:0]  sense_gain;
  logic        sleep_req;
  logic [2:0]  lock_partition_select;
  logic        write_latch;
  logic [7:0]  rx [8];
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #5 sys_clk = ~sys_clk;

  spc_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .so(so), .so_oe_n(so_oe_n), .status_flags(status_flags),
    .cfg_word(cfg_word), .cfet_on(cfet_on), .dfet_on(dfet_on),
    .balance_on(balance_on), .sense_gain(sense_gain),
    .sleep_req(sleep_req), .lock_partition_select(lock_partition_select),
    .write_latch(write_latch));
  // a released pin shows the inverse of its parked level, so stale data
  // cannot pass for a read byte
  assign so_pin = so_oe_n ? ~so : so;
  spc_host host (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si),
    .so(so_pin));

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // one framed command of n bytes, first byte highest in b
  task run(input logic [63:0] b, input int n);
    logic [7:0] r;
    host.open();
    for (int i = 0; i < n; i++) begin
      host.xfer(b[8*(n-1-i) +: 8], r);
      rx[i] = r;
    end
    host.close();
  endtask : run

  task test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // hang guard, the whole sequence needs well under this
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({11'h0, so_oe_n, write_latch, lock_partition_select}, 16'h0010,
        "reset state");
    chk(cfg_word, 16'h0000, "reset config");
    run(64'h09A53C, 3);
    chk(cfg_word, 16'hA53C, "config write");
    run(64'h06, 1);
    run(64'h020020A53C, 5); // keep the new settings in the array
    run(64'h0A01, 2);
    chk({7'h0, sleep_req, sense_gain, balance_on, dfet_on, cfet_on},
        16'h0000, "partial control write");
    run(64'h0A015B, 3);
    chk({7'h0, sleep_req, sense_gain, balance_on, dfet_on, cfet_on},
        16'h015B, "control write");
    run(64'h0B0000, 3); // back to back after control write
    chk({8'h00, rx[1]}, 16'h0005, "status byte");
    chk({8'h00, rx[2]}, 16'h0005, "status repeat");
    run(64'h06, 1);
    run(64'h0201FF5A, 4);
    run(64'h06, 1);
    run(64'h020000AA, 4);
    run(64'h06, 1);
    chk({15'h0, write_latch}, 16'h0001, "latch set");
    run(64'h0103, 2);
    chk({13'h0, lock_partition_select}, 16'h0003, "lock code");
    chk({15'h0, write_latch}, 16'h0000, "latch after lock");
    run(64'h0105, 2); // latch is clear, so nothing may change
    chk({13'h0, lock_partition_select}, 16'h0003, "lock kept");
    run(64'h0500, 2);
    chk({8'h00, rx[1]}, 16'h0003, "lock read back");
    run(64'h06, 1);
    run(64'h04, 1);
    chk({15'h0, write_latch}, 16'h0000, "latch cleared");
    run(64'h06, 1);
    run(64'h02011055, 4);
    host.gap = 40;
    run(64'h0301FF000000, 6); // stalled host, stream over the top
    chk({8'h00, rx[3]}, 16'h005A, "read top");
    chk({8'h00, rx[4]}, 16'h00AA, "read wrap");
    chk({8'h00, rx[5]}, 16'h00FF, "read next");
    host.gap = 0;
    run(64'h03011000, 4);
    chk({8'h00, rx[3]}, 16'h00FF, "locked byte kept");
    chk({15'h0, so_oe_n}, 16'h0001, "released after read");
    run(64'h0300200000, 5);
    chk({8'h00, rx[3]}, 16'h00A5, "config copy high");
    chk({8'h00, rx[4]}, 16'h003C, "config copy low");
    test_done();
  end
endmodule : spc_port_tb

bind spc_port spc_port_chk chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .cs_n(cs_n), .sck(sck), .so(so), .so_oe_n(so_oe_n),
  .cfg_word(cfg_word), .cfet_on(cfet_on), .dfet_on(dfet_on),
  .balance_on(balance_on), .sense_gain(sense_gain),
  .sleep_req(sleep_req), .lock_partition_select(lock_partition_select),
  .write_latch(write_latch));

`default_nettype wire
